/* File: common/csmof_regs.vh */
// register offsets, fields and reset values for the color matrix formatter
`ifndef CSMOF_REGS_VH
`define CSMOF_REGS_VH
`define CSMOF_ADDR_SYNC_CTRL 12'h0084
`define CSMOF_ADDR_FORMAT 12'h0088
`define CSMOF_ADDR_SCALE 12'h008C
`define CSMOF_ADDR_STATUS 12'h0090
`define CSMOF_ADDR_COEF_BASE 12'h0000
`define CSMOF_COEF_COUNT 12
`define CSMOF_BIT_VSYNC_FILTER 5
`define CSMOF_BIT_REGEN_HSYNC 7
`define CSMOF_SYNC_CTRL_RESET 8'h00
`define CSMOF_FORMAT_RESET 3'h0
`define CSMOF_SCALE_RESET 2'h0
`define CSMOF_FMT_RGB444 3'h0
`define CSMOF_FMT_YC444 3'h1
`define CSMOF_FMT_YC422 3'h2
`define CSMOF_FMT_DUAL422 3'h3
`define CSMOF_FMT_DDR444 3'h4
`define CSMOF_FMT_DDR422 3'h5
`define CSMOF_FMT_BT656 3'h6
`define CSMOF_PIPE_FLUSH 3'h6
`define CSMOF_VS_GUARD 4'h2
`endif

/* File: rtl/csmof_formatter.v */
// color matrix, chroma decimation, de/sav/eav and output formatting
//
// Local design decisions: the APB interface to the registers and the address map.
`timescale 1ns/1ns
`include "csmof_regs.vh"

module csmof_formatter
#(
   parameter DW = 12,
   parameter CW = 13
)
(
   // clock and reset
   input wire mclk_i,
   input wire reset_n_i,
   // apb slave
   input wire psel_i,
   input wire penable_i,
   input wire pwrite_i,
   input wire [11:0] paddr_i,
   input wire [31:0] pwdata_i,
   output reg [31:0] prdata_o,
   output wire pready_o,
   output wire pslverr_o,
   // pixel input, sampled by mclk
   input wire [DW-1:0] red_cr_i,
   input wire [DW-1:0] green_y_i,
   input wire [DW-1:0] blue_cb_i,
   input wire de_i,
   // external syncs, asynchronous
   input wire hsync_raw_i,
   input wire hsync_regen_i,
   input wire vsync_i,
   // formatted output
   output reg [DW-1:0] port_a_o,
   output reg [DW-1:0] port_b_o,
   output reg [DW-1:0] port_c_o,
   output reg de_o,
   output reg hsync_o,
   output reg filtered_vertical_sync_out_o,
   output reg field_odd_o,
   output reg data_clk_o,
   output reg valid_o
);

   localparam PW = DW + CW + 4;
   // signed so that rounding and the arithmetic shift keep the sign
   localparam signed [PW-1:0] ONE = {{(PW-1){1'b0}}, 1'b1};

   // saturate a signed sum to 0..2^DW-1
   function [DW-1:0] sat;
      input signed [PW-1:0] v;
      begin
         if (v[PW-1])
            sat = {DW{1'b0}};
         else if (|v[PW-2:DW])
            sat = {DW{1'b1}};
         else
            sat = v[DW-1:0];
      end
   endfunction

   // write strobe decode for a given address
   function wsel;
      input [11:0] a;
      begin
         wsel = psel_i && penable_i && pwrite_i && (paddr_i == a);
      end
   endfunction

   reg [7:0] sync_ctrl_reg;
   reg [2:0] format_reg;
   reg [1:0] scale_reg;
   reg signed [CW-1:0] coef_reg [0:11];
   reg [2:0] flush_reg;
   reg running_reg;
   wire vs_filter_en = sync_ctrl_reg[`CSMOF_BIT_VSYNC_FILTER];
   wire use_regen = sync_ctrl_reg[`CSMOF_BIT_REGEN_HSYNC];
   wire coef_hit = (paddr_i[11:6] == 6'h00) && (paddr_i[1:0] == 2'h0) &&
      (paddr_i[5:2] < 4'd12);
   wire map_hit = coef_hit || paddr_i == `CSMOF_ADDR_SYNC_CTRL ||
      paddr_i == `CSMOF_ADDR_FORMAT || paddr_i == `CSMOF_ADDR_SCALE ||
      paddr_i == `CSMOF_ADDR_STATUS;

   assign pready_o = 1'b1;
   assign pslverr_o = psel_i && penable_i && !map_hit;

   integer k;
   always @(posedge mclk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         sync_ctrl_reg <= `CSMOF_SYNC_CTRL_RESET;
         format_reg <= `CSMOF_FORMAT_RESET;
         scale_reg <= `CSMOF_SCALE_RESET;
         for (k = 0; k < 12; k = k + 1)
            coef_reg[k] <= {CW{1'b0}};
      end
      else
      begin
         if (wsel(`CSMOF_ADDR_SYNC_CTRL))
            sync_ctrl_reg <= pwdata_i[7:0];
         if (wsel(`CSMOF_ADDR_FORMAT))
            format_reg <= pwdata_i[2:0];
         if (wsel(`CSMOF_ADDR_SCALE))
            scale_reg <= pwdata_i[1:0];
         if (psel_i && penable_i && pwrite_i && coef_hit)
            coef_reg[paddr_i[5:2]] <= pwdata_i[CW-1:0];
      end
   end

   always @*
   begin
      prdata_o = 32'h0000_0000;
      if (coef_hit)
         prdata_o = {{(32-CW){1'b0}}, coef_reg[paddr_i[5:2]]};
      else if (paddr_i == `CSMOF_ADDR_SYNC_CTRL)
         prdata_o = {24'h00_0000, sync_ctrl_reg};
      else if (paddr_i == `CSMOF_ADDR_FORMAT)
         prdata_o = {29'h0000_0000, format_reg};
      else if (paddr_i == `CSMOF_ADDR_SCALE)
         prdata_o = {30'h0000_0000, scale_reg};
      else if (paddr_i == `CSMOF_ADDR_STATUS)
         prdata_o = {28'h000_0000, running_reg, field_odd_o,
            filtered_vertical_sync_out_o, hsync_o};
   end

   // three-flop synchronisers for asynchronous sync pins
   reg [2:0] hraw_s, hreg_s, vs_s;
   reg hs_st_reg, vs_st_reg;
   always @(posedge mclk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         hraw_s <= 3'h0;
         hreg_s <= 3'h0;
         vs_s <= 3'h0;
         hs_st_reg <= 1'b0;
         vs_st_reg <= 1'b0;
      end
      else
      begin
         hraw_s <= {hraw_s[1:0], hsync_raw_i};
         hreg_s <= {hreg_s[1:0], hsync_regen_i};
         vs_s <= {vs_s[1:0], vsync_i};
         if (use_regen ? (hreg_s[2] == hreg_s[1]) : (hraw_s[2] == hraw_s[1]))
            hs_st_reg <= use_regen ? hreg_s[2] : hraw_s[2];
         if (vs_s[2] == vs_s[1])
            vs_st_reg <= vs_s[2];
      end
   end

   // vsync filter: guard after hsync edge, field from line position
   reg hs_d_reg, vs_d_reg, vs_pend_reg;
   reg [15:0] line_pos_reg, line_len_reg;
   reg [3:0] guard_reg;
   wire hs_rise = hs_st_reg && !hs_d_reg;
   wire vs_rise = vs_st_reg && !vs_d_reg;
   wire vs_fall = !vs_st_reg && vs_d_reg;
   always @(posedge mclk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         hs_d_reg <= 1'b0;
         vs_d_reg <= 1'b0;
         vs_pend_reg <= 1'b0;
         line_pos_reg <= 16'h0000;
         line_len_reg <= 16'h0000;
         guard_reg <= 4'h0;
         filtered_vertical_sync_out_o <= 1'b0;
         field_odd_o <= 1'b0;
         hsync_o <= 1'b0;
      end
      else
      begin
         hs_d_reg <= hs_st_reg;
         vs_d_reg <= vs_st_reg;
         hsync_o <= hs_st_reg;
         if (hs_rise)
         begin
            line_pos_reg <= 16'h0000;
            line_len_reg <= line_pos_reg;
            guard_reg <= `CSMOF_VS_GUARD;
         end
         else
         begin
            line_pos_reg <= line_pos_reg + 16'h0001;
            if (guard_reg != 4'h0)
               guard_reg <= guard_reg - 4'h1;
         end
         if (!vs_filter_en)
         begin
            filtered_vertical_sync_out_o <= vs_st_reg;
            vs_pend_reg <= 1'b0;
         end
         else
         begin
            // hold vsync rise off the hsync edge
            if (vs_rise || vs_pend_reg)
            begin
               if (hs_rise || guard_reg != 4'h0)
                  vs_pend_reg <= 1'b1;
               else
               begin
                  vs_pend_reg <= 1'b0;
                  filtered_vertical_sync_out_o <= 1'b1;
               end
            end
            if (vs_fall)
            begin
               vs_pend_reg <= 1'b0;
               filtered_vertical_sync_out_o <= 1'b0;
            end
            // mid-line vsync marks the other field
            if (vs_rise)
               field_odd_o <= (line_pos_reg > {2'b00, line_len_reg[15:2]}) &&
                  (line_pos_reg < line_len_reg - {2'b00, line_len_reg[15:2]});
         end
      end
   end

   // input registers and de delay line for the pixel pipeline; syncs are not delayed here
   reg [DW-1:0] in_reg [0:2];
   reg [4:0] de_pipe;
   always @(posedge mclk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         in_reg[0] <= {DW{1'b0}};
         in_reg[1] <= {DW{1'b0}};
         in_reg[2] <= {DW{1'b0}};
         de_pipe <= 5'h00;
      end
      else
      begin
         in_reg[0] <= red_cr_i;
         in_reg[1] <= green_y_i;
         in_reg[2] <= blue_cb_i;
         de_pipe <= {de_pipe[3:0], de_i};
      end
   end

   reg signed [PW-1:0] prod_reg [0:8];
   reg signed [PW-1:0] sum_reg [0:2];
   reg [DW-1:0] row_reg [0:2];
   genvar r;
   generate
      for (r = 0; r < 3; r = r + 1)
      begin : g_row
         wire signed [PW-1:0] x0 = {{(PW-DW){1'b0}}, in_reg[0]};
         wire signed [PW-1:0] x1 = {{(PW-DW){1'b0}}, in_reg[1]};
         wire signed [PW-1:0] x2 = {{(PW-DW){1'b0}}, in_reg[2]};
         // fourth coefficient as offset, scaled to input units
         wire signed [PW-1:0] off = {{(PW-CW){coef_reg[r*4+3][CW-1]}},
            coef_reg[r*4+3]} <<< (DW-8);
         wire signed [PW-1:0] tot = sum_reg[r] <<< scale_reg;
         always @(posedge mclk_i or negedge reset_n_i)
         begin
            if (!reset_n_i)
            begin
               prod_reg[r*3] <= {PW{1'b0}};
               prod_reg[r*3+1] <= {PW{1'b0}};
               prod_reg[r*3+2] <= {PW{1'b0}};
               sum_reg[r] <= {PW{1'b0}};
               row_reg[r] <= {DW{1'b0}};
            end
            else
            begin
               prod_reg[r*3] <= x0 * coef_reg[r*4];
               prod_reg[r*3+1] <= x1 * coef_reg[r*4+1];
               prod_reg[r*3+2] <= x2 * coef_reg[r*4+2];
               sum_reg[r] <= prod_reg[r*3] + prod_reg[r*3+1] +
                  prod_reg[r*3+2] + (off <<< 12);
               row_reg[r] <= sat((tot + (ONE <<< 11)) >>> 12);
            end
         end
      end
   endgenerate

   // chroma average of pixel pairs, with rounding
   reg [DW-1:0] cb_prev, cr_prev, chroma_reg, y_reg, y_prev;
   reg [DW-1:0] rgb_reg [0:2];
   reg cb_phase, de_f, ddr_half;
   wire [DW:0] cb_avg = {1'b0, cb_prev} + {1'b0, row_reg[2]} +
      {{DW{1'b0}}, 1'b1};
   wire [DW:0] cr_avg = {1'b0, cr_prev} + {1'b0, row_reg[0]} +
      {{DW{1'b0}}, 1'b1};
   wire de_m = de_pipe[4];
   wire [7:0] bt_code = {1'b1, field_odd_o, filtered_vertical_sync_out_o,
      !de_m, field_odd_o ^ filtered_vertical_sync_out_o,
      field_odd_o ^ !de_m, filtered_vertical_sync_out_o ^ !de_m,
      field_odd_o ^ filtered_vertical_sync_out_o ^ !de_m};
   always @(posedge mclk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         cb_prev <= {DW{1'b0}};
         cr_prev <= {DW{1'b0}};
         chroma_reg <= {DW{1'b0}};
         y_reg <= {DW{1'b0}};
         y_prev <= {DW{1'b0}};
         rgb_reg[0] <= {DW{1'b0}};
         rgb_reg[1] <= {DW{1'b0}};
         rgb_reg[2] <= {DW{1'b0}};
         cb_phase <= 1'b0;
         de_f <= 1'b0;
         ddr_half <= 1'b0;
         flush_reg <= 3'h0;
         running_reg <= 1'b0;
         valid_o <= 1'b0;
         data_clk_o <= 1'b0;
         de_o <= 1'b0;
         port_a_o <= {DW{1'b0}};
         port_b_o <= {DW{1'b0}};
         port_c_o <= {DW{1'b0}};
      end
      else
      begin
         cb_prev <= row_reg[2];
         cr_prev <= row_reg[0];
         y_prev <= y_reg;
         y_reg <= row_reg[1];
         rgb_reg[0] <= row_reg[0];
         rgb_reg[1] <= row_reg[1];
         rgb_reg[2] <= row_reg[2];
         de_f <= de_m;
         ddr_half <= !ddr_half;
         // cb first at each de rise
         cb_phase <= (de_m && !de_f) ? 1'b1 : !cb_phase;
         chroma_reg <= cb_phase ? cb_avg[DW:1] : cr_avg[DW:1];
         data_clk_o <= ddr_half;
         if (flush_reg != `CSMOF_PIPE_FLUSH)
            flush_reg <= flush_reg + 3'h1;
         else
            running_reg <= 1'b1;
         valid_o <= running_reg && de_f;
         de_o <= de_f;
         case (format_reg)
            `CSMOF_FMT_RGB444, `CSMOF_FMT_YC444:
            begin
               port_a_o <= rgb_reg[0];
               port_b_o <= rgb_reg[1];
               port_c_o <= rgb_reg[2];
            end
            `CSMOF_FMT_YC422:
            begin
               port_a_o <= chroma_reg;
               port_b_o <= y_reg;
               port_c_o <= {DW{1'b0}};
            end
            `CSMOF_FMT_DUAL422:
            begin
               port_a_o <= chroma_reg;
               port_b_o <= y_reg;
               port_c_o <= y_prev;
            end
            `CSMOF_FMT_DDR444:
            begin
               port_a_o <= ddr_half ? rgb_reg[0] : rgb_reg[1];
               port_b_o <= ddr_half ? rgb_reg[1] : rgb_reg[2];
               port_c_o <= {DW{1'b0}};
            end
            `CSMOF_FMT_DDR422:
            begin
               port_a_o <= ddr_half ? y_reg : chroma_reg;
               port_b_o <= {DW{1'b0}};
               port_c_o <= {DW{1'b0}};
            end
            `CSMOF_FMT_BT656:
            begin
               port_b_o <= {DW{1'b0}};
               port_c_o <= {DW{1'b0}};
               if (de_m != de_f)
                  port_a_o <= {bt_code, {(DW-8){1'b0}}};
               else
                  port_a_o <= de_f ? (cb_phase ? chroma_reg : y_reg)
                     : {DW{1'b0}};
            end
            default:
            begin
               port_a_o <= {DW{1'b0}};
               port_b_o <= {DW{1'b0}};
               port_c_o <= {DW{1'b0}};
            end
         endcase
      end
   end

endmodule

/* File: verification/csmof_formatter_chk.sv */
// port assertions for the color matrix formatter
`timescale 1ns/1ns
`include "csmof_regs.vh"
module csmof_chk
(
   // clock and reset
   input wire logic mclk_i,
   input wire logic reset_n_i,
   // apb
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [11:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic [31:0] prdata_o,
   input wire logic pready_o,
   input wire logic pslverr_o,
   // video status
   input wire logic de_o,
   input wire logic hsync_o,
   input wire logic filtered_vertical_sync_out_o,
   input wire logic field_odd_o,
   input wire logic data_clk_o,
   input wire logic valid_o
);
   wire mapped;
   wire vs_out;
   logic filt_reg;
   logic [2:0] run_reg;
   default clocking dc @(posedge mclk_i); endclocking
   default disable iff (!reset_n_i);
   assign vs_out = filtered_vertical_sync_out_o;
   assign mapped = (paddr_i < 12'h030 && paddr_i[1:0] == 2'h0) ||
      paddr_i == `CSMOF_ADDR_SYNC_CTRL || paddr_i == `CSMOF_ADDR_FORMAT ||
      paddr_i == `CSMOF_ADDR_SCALE || paddr_i == `CSMOF_ADDR_STATUS;
   // filter state and cycles since reset
   always_ff @(posedge mclk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         filt_reg <= 1'b0;
         run_reg <= 3'h0;
      end
      else
      begin
         if (psel_i && penable_i && pwrite_i &&
             paddr_i == `CSMOF_ADDR_SYNC_CTRL)
            filt_reg <= pwdata_i[`CSMOF_BIT_VSYNC_FILTER];
         if (run_reg != 3'h7)
            run_reg <= run_reg + 3'h1;
      end
   end
   sequence bad_acc_s;
      psel_i && penable_i && !mapped;
   endsequence
   sequence vs_lead_s;
      !vs_out ##1 vs_out && filt_reg;
   endsequence
   ready_high_a: assert property (pready_o)
      else $error("pready low");
   err_unmapped_a: assert property (bad_acc_s |-> pslverr_o)
      else $error("no error on unmapped access");
   read_zero_a: assert property
      (bad_acc_s ##0 !pwrite_i |-> prdata_o == 32'h0000_0000)
      else $error("unmapped read not zero");
   vs_edge_a: assert property (vs_lead_s |-> !$rose(hsync_o) &&
      !($past(hsync_o) && !$past(hsync_o, 2)))
      else $error("vsync out rose next to hsync rise");
   flush_gap_a: assert property (valid_o |-> run_reg >= 3'h6)
      else $error("valid before pipeline flush");
   valid_de_a: assert property (valid_o |-> de_o)
      else $error("valid without de");
   dclk_half_a: assert property ($rose(data_clk_o) |=> !data_clk_o)
      else $error("data clock high too long");
   // field only moves with a vsync out rise, guard delay included
   field_hold_a: assert property
      ($changed(field_odd_o) |-> ##[0:4] $rose(vs_out))
      else $error("field moved away from vsync");
endmodule
bind csmof_formatter csmof_chk chk
(
   .mclk_i(mclk_i), .reset_n_i(reset_n_i), .psel_i(psel_i),
   .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
   .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
   .pslverr_o(pslverr_o), .de_o(de_o), .hsync_o(hsync_o),
   .filtered_vertical_sync_out_o(filtered_vertical_sync_out_o),
   .field_odd_o(field_odd_o), .data_clk_o(data_clk_o), .valid_o(valid_o)
);

/* File: verification/csmof_sink.sv */
// downstream model: skips flush sets, keeps last valid pixel
`timescale 1ns/1ns
module csmof_sink
(
   // clock and reset
   input wire logic mclk_i,
   input wire logic reset_n_i,
   // formatted pixel
   input wire logic [11:0] port_a_i,
   input wire logic [11:0] port_b_i,
   input wire logic [11:0] port_c_i,
   input wire logic de_i,
   input wire logic valid_i,
   // last accepted pixel
   output logic [11:0] got_a_o,
   output logic [11:0] got_b_o,
   output logic [11:0] got_c_o,
   output int n_valid_o
);
   always_ff @(posedge mclk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         got_a_o <= 12'hA5A;
         got_b_o <= 12'hA5A;
         got_c_o <= 12'hA5A;
         n_valid_o <= 0;
      end
      else if (valid_i && de_i)
      begin
         got_a_o <= port_a_i;
         got_b_o <= port_b_i;
         got_c_o <= port_c_i;
         n_valid_o <= n_valid_o + 1;
      end
   end
endmodule

/* File: verification/test_color_space_matrix_output_formatter.sv */
// bench for the color matrix formatter: apb tasks and pixel checks
`timescale 1ns/1ns
`include "csmof_regs.vh"
module test_color_space_matrix_output_formatter;
   logic mclk_i = 1'b0, reset_n_i = 1'b0;
   logic psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
   logic [11:0] paddr_i = 12'h000;
   logic [31:0] pwdata_i = 32'h0000_0000;
   logic [11:0] r_i = 12'h000, g_i = 12'h000, b_i = 12'h000;
   logic de_i = 1'b0, hraw_i = 1'b0, hreg_i = 1'b0, vs_i = 1'b0;
   logic vs_seen = 1'b0;
   logic [31:0] prdata_o, rd;
   logic pready_o, pslverr_o, err;
   logic [11:0] pa, pb, pc, got_a, got_b, got_c;
   logic de_o, hs_o, vs_o, fld_o, dclk_o, val_o;
   logic [11:0] ra [4] = '{`CSMOF_ADDR_SYNC_CTRL, `CSMOF_ADDR_FORMAT,
      `CSMOF_ADDR_SCALE, 12'h000};
   int n_valid;
   int n_mismatch = 0;
   int compares = 0;
   csmof_formatter #(.DW(12), .CW(13)) dut
   (
      .mclk_i(mclk_i), .reset_n_i(reset_n_i), .psel_i(psel_i),
      .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
      .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
      .pslverr_o(pslverr_o), .red_cr_i(r_i), .green_y_i(g_i),
      .blue_cb_i(b_i), .de_i(de_i), .hsync_raw_i(hraw_i),
      .hsync_regen_i(hreg_i), .vsync_i(vs_i), .port_a_o(pa),
      .port_b_o(pb), .port_c_o(pc), .de_o(de_o), .hsync_o(hs_o),
      .filtered_vertical_sync_out_o(vs_o), .field_odd_o(fld_o),
      .data_clk_o(dclk_o), .valid_o(val_o)
   );
   csmof_sink sink
   (
      .mclk_i(mclk_i), .reset_n_i(reset_n_i), .port_a_i(pa),
      .port_b_i(pb), .port_c_i(pc), .de_i(de_o), .valid_i(val_o),
      .got_a_o(got_a), .got_b_o(got_b), .got_c_o(got_c), .n_valid_o(n_valid)
   );
   always #20 mclk_i = ~mclk_i;
   always @(posedge mclk_i)
      if (vs_o) vs_seen <= 1'b1;
   task chk(input logic [31:0] s, input logic [31:0] e);
      compares++;
      if (s !== e)
      begin
         n_mismatch++;
         $display("mismatch at %0t: got %h want %h", $time, s, e);
      end
   endtask
   task report_and_stop;
      $display("compares %0d mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int i;
      @(posedge mclk_i);
      psel_i <= 1'b1;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge mclk_i);
      penable_i <= 1'b1;
      i = 0;
      do
      begin
         @(posedge mclk_i);
         i++;
      end
      while (pready_o !== 1'b1 && i < 16);
      rd = prdata_o;
      err = pslverr_o;
      if (i == 16)
      begin
         n_mismatch++;
         report_and_stop;
      end
      psel_i <= 1'b0;
      penable_i <= 1'b0;
   endtask
   task pix(input logic [11:0] a, input logic [11:0] b, input logic [11:0] c);
      repeat (12) @(posedge mclk_i);
      chk(got_a, a);
      chk(got_b, b);
      chk(got_c, c);
   endtask
   // eight-cycle lines, vsync four lines long, at line start or mid line
   task frame(input logic mid);
      for (int l = 0; l < 12; l++)
      begin
         hreg_i <= 1'b1;
         if (!mid)
            vs_i <= l >= 4 && l < 8;
         repeat (4) @(posedge mclk_i);
         hreg_i <= 1'b0;
         if (mid)
            vs_i <= l >= 4 && l < 8;
         repeat (4) @(posedge mclk_i);
      end
   endtask
   initial
   begin
      repeat (12) @(posedge mclk_i);
      reset_n_i <= 1'b1;
      for (int k = 0; k < 4; k++)
      begin
         apb(1'b0, ra[k], 32'h0000_0000);
         chk(rd, 32'h0000_0000);
      end
      apb(1'b1, `CSMOF_ADDR_SYNC_CTRL, 32'h0000_00A0);
      apb(1'b0, `CSMOF_ADDR_SYNC_CTRL, 32'h0000_0000);
      chk(rd, 32'h0000_00A0);
      for (int f = 0; f < 7; f++)
      begin
         apb(1'b1, `CSMOF_ADDR_FORMAT, 32'(f));
         apb(1'b0, `CSMOF_ADDR_FORMAT, 32'h0000_0000);
         chk(rd, 32'(f));
      end
      apb(1'b1, 12'h004, 32'h0000_1ABC);
      apb(1'b0, 12'h004, 32'h0000_0000);
      chk(rd, 32'h0000_1ABC);
      apb(1'b1, 12'h004, 32'h0000_0000);
      apb(1'b0, 12'h040, 32'h0000_0000);
      chk(rd, 32'h0000_0000);
      chk(err, 32'h0000_0001);
      $display("test registers done");
      apb(1'b1, `CSMOF_ADDR_FORMAT, 32'h0000_0000);
      r_i <= 12'h123;
      g_i <= 12'h456;
      b_i <= 12'h789;
      de_i <= 1'b1;
      for (int e = 1; e < 4; e++)
      begin
         apb(1'b1, `CSMOF_ADDR_SCALE, 32'(e));
         apb(1'b1, 12'h000, 32'(4096 >> e));
         apb(1'b1, 12'h014, 32'(4096 >> e));
         apb(1'b1, 12'h028, 32'(4096 >> e));
         pix(12'h123, 12'h456, 12'h789);
      end
      chk(32'(n_valid != 0), 32'h0000_0001);
      apb(1'b1, 12'h000, 32'h0000_0000);
      apb(1'b1, 12'h008, 32'h0000_0200);
      pix(12'h789, 12'h456, 12'h789);
      apb(1'b1, 12'h000, 32'h0000_0200);
      r_i <= 12'hC00;
      b_i <= 12'hC00;
      pix(12'hFFF, 12'h456, 12'hC00);
      apb(1'b1, 12'h008, 32'h0000_0000);
      apb(1'b1, 12'h000, 32'h0000_1E00);
      pix(12'h000, 12'h456, 12'hC00);
      apb(1'b1, 12'h000, 32'h0000_0200);
      apb(1'b1, `CSMOF_ADDR_FORMAT, 32'h0000_0002);
      pix(12'hC00, 12'h456, 12'h000);
      apb(1'b1, `CSMOF_ADDR_FORMAT, 32'h0000_0003);
      pix(12'hC00, 12'h456, 12'h456);
      $display("test matrix done");
      apb(1'b1, `CSMOF_ADDR_SYNC_CTRL, 32'h0000_0000);
      hraw_i <= 1'b1;
      repeat (8) @(posedge mclk_i);
      chk(hs_o, 32'h0000_0001);
      apb(1'b1, `CSMOF_ADDR_SYNC_CTRL, 32'h0000_00A0);
      repeat (8) @(posedge mclk_i);
      chk(hs_o, 32'h0000_0000);
      hraw_i <= 1'b0;
      $display("test hsync select done");
      frame(1'b1);
      chk(fld_o, 32'h0000_0001);
      frame(1'b0);
      chk(fld_o, 32'h0000_0000);
      chk(vs_seen, 32'h0000_0001);
      $display("test vsync filter done");
      report_and_stop;
   end
   initial
   begin
      #1000000;
      n_mismatch++;
      report_and_stop;
   end
endmodule
